// >>> tcc_pkg.sv
package tcc_pkg;
	// Register byte offsets
	localparam logic [4:0] OFF_CTRL    = 5'h00;
	localparam logic [4:0] OFF_COUNT   = 5'h04;
	localparam logic [4:0] OFF_MATCH_A = 5'h08;
	localparam logic [4:0] OFF_MATCH_B = 5'h0C;
	localparam logic [4:0] OFF_CAPTURE = 5'h10;
	localparam logic [4:0] OFF_FLAGS   = 5'h14;
	localparam logic [4:0] OFF_FORCE   = 5'h18;
	localparam logic [4:0] OFF_PORT    = 5'h1C;

	// Control register fields
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_CLK_LSB    = 4;
	localparam int CTRL_ACT_A_LSB  = 8;
	localparam int CTRL_ACT_B_LSB  = 10;

	// Flag bit positions
	localparam int FLG_OVF = 0;
	localparam int FLG_MA  = 1;
	localparam int FLG_MB  = 2;
	localparam int FLG_CAP = 3;

	// Port register fields
	localparam int PORT_OUT_LSB = 0;
	localparam int PORT_DIR_LSB = 2;
	localparam int PORT_WAVE_LSB = 4;

	// Waveform modes used by the counter
	localparam logic [3:0] MODE_NORMAL    = 4'h0;
	localparam logic [3:0] MODE_CTC_MATCH = 4'h4;
	localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
	localparam logic [3:0] MODE_FAST_8    = 4'h5;
	localparam logic [3:0] MODE_FAST_9    = 4'h6;
	localparam logic [3:0] MODE_FAST_10   = 4'h7;
	localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
	localparam logic [3:0] MODE_FAST_MTCH = 4'hF;

	// Output actions
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// Clock select codes and division factors
	localparam logic [2:0] CLK_STOP  = 3'h0;
	localparam logic [2:0] CLK_DIV1  = 3'h1;
	localparam logic [2:0] CLK_DIV8  = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h3;
	localparam logic [2:0] CLK_DIV256 = 3'h4;
	localparam logic [2:0] CLK_DIV1024 = 3'h5;
	localparam logic [9:0] DIV8_MASK    = 10'h007;
	localparam logic [9:0] DIV64_MASK   = 10'h03F;
	localparam logic [9:0] DIV256_MASK  = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;

	// Counter limits and fixed tops
	localparam logic [15:0] CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CNT_FLOOR = 16'h0000;
	localparam logic [15:0] TOP_8     = 16'h00FF;
	localparam logic [15:0] TOP_9     = 16'h01FF;
	localparam logic [15:0] TOP_10    = 16'h03FF;
endpackage

// >>> tcc_timer16.sv
// Contract
// - Force strobe applies output action in non-PWM
// - Force sets no flag, leaves counter alone
// - Counter write blocks matches next timer tick
// - Variable-top PWM: written top missed, runs on
// - Output bit held across mode changes
// - Output action field unbuffered, applies at once
// - Reset clears output bits to zero
// - Nonzero action overrides port value, direction kept
// - Action field never touches input capture
// - Action zero leaves output unchanged
// - Only wave mode decides counting sequence
// - Non-PWM action sets, clears or toggles
// - Mode 0 counts up, wraps FFFF to 0
// - Mode 0 counter writable any time
// - Clear-on-match clears on A (4) or capture (12)
// - Top unbuffered; below count means wrap first
// - Reaching a top taken from A or capture sets that flag
// - Toggle on A in clear-on-match mode
// - Prescaler offers 1, 8, 64, 256, 1024
// - Clear-on-match overflow on MAX to zero
// - Real match sets its flag at tick
// - Match writes go straight to compare register
`timescale 1ns/1ns
`default_nettype none

module tcc_timer16 #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	// Avalon-MM slave
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Input capture event
	input  wire logic              capture_event,
	// Wave pins, channel A in bit 0
	output logic [1:0]             wave_pin_o,
	output logic [1:0]             wave_pin_oe
);

	logic              rst_meta_q;
	logic              rst_sync_q;
	logic              ack_q;
	logic [31:0]       rdata_q;
	logic [3:0]        wave_mode_sel_q;
	logic [2:0]        clk_sel_q;
	logic [1:0]        out_action_sel_a_q;
	logic [1:0]        out_action_sel_b_q;
	logic [CNT_W-1:0]  count_value_q;
	logic [CNT_W-1:0]  match_value_a_q;
	logic [CNT_W-1:0]  match_value_b_q;
	logic [CNT_W-1:0]  capture_value_q;
	logic              overflow_flag_q;
	logic              match_flag_a_q;
	logic              match_flag_b_q;
	logic              capture_flag_q;
	logic              block_q;
	logic [9:0]        div_q;
	logic [1:0]        port_out_q;
	logic [1:0]        wave_pin_dir_q;
	logic              wave_out_bit_a_q;
	logic              wave_out_bit_b_q;
	logic              wr_take;
	logic              tick;
	logic              pwm_mode;
	logic              ctc_mode;
	logic [CNT_W-1:0]  top_value;
	logic              hit_a;
	logic              hit_b;
	logic              hit_top;
	logic              at_max;
	logic              force_a;
	logic              force_b;
	logic              wr_ctrl;
	logic              wr_count;
	logic              wr_flags;
	logic              wr_port;
	logic              wr_force;
	logic              wr_match_a;
	logic              wr_match_b;
	logic              wr_capture;
	logic [1:0]        wave_pin_q;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic apply_action(input logic cur, input logic [1:0] act);
		unique case (act)
			tcc_pkg::ACT_NONE:   apply_action = cur;
			tcc_pkg::ACT_TOGGLE: apply_action = ~cur;
			tcc_pkg::ACT_CLEAR:  apply_action = 1'b0;
			tcc_pkg::ACT_SET:    apply_action = 1'b1;
		endcase
	endfunction

	// Timer clock enable when the free-running divider wraps under a mask
	function automatic logic div_done(input logic [9:0] cnt, input logic [9:0] mask);
		div_done = (cnt & mask) == mask;
	endfunction

	// Modes that take top from the capture register shut the capture input off
	function automatic logic capture_sets_top(input logic [3:0] mode);
		capture_sets_top = (mode == tcc_pkg::MODE_CTC_CAPT)
			|| (mode == tcc_pkg::MODE_FAST_CAPT);
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Bus answers on the second edge of each request
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata    = rdata_q;
	assign wr_take         = avs_write & ack_q;

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read & ~ack_q) begin
			unique case (avs_address)
				tcc_pkg::OFF_CTRL: rdata_q <= {20'h0_0000, out_action_sel_b_q,
					out_action_sel_a_q, 1'b0, clk_sel_q, wave_mode_sel_q};
				tcc_pkg::OFF_COUNT:   rdata_q <= {16'h0000, count_value_q};
				tcc_pkg::OFF_MATCH_A: rdata_q <= {16'h0000, match_value_a_q};
				tcc_pkg::OFF_MATCH_B: rdata_q <= {16'h0000, match_value_b_q};
				tcc_pkg::OFF_CAPTURE: rdata_q <= {16'h0000, capture_value_q};
				tcc_pkg::OFF_FLAGS: rdata_q <= {28'h000_0000, capture_flag_q,
					match_flag_b_q, match_flag_a_q, overflow_flag_q};
				tcc_pkg::OFF_PORT: rdata_q <= {26'h000_0000, wave_out_bit_b_q,
					wave_out_bit_a_q, wave_pin_dir_q, port_out_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Write decode
	assign wr_ctrl  = wr_take & (avs_address == tcc_pkg::OFF_CTRL);
	assign wr_count = wr_take & (avs_address == tcc_pkg::OFF_COUNT);
	assign wr_flags = wr_take & (avs_address == tcc_pkg::OFF_FLAGS) & avs_byteenable[0];
	assign wr_port  = wr_take & (avs_address == tcc_pkg::OFF_PORT) & avs_byteenable[0];
	assign wr_force   = wr_take & (avs_address == tcc_pkg::OFF_FORCE) & avs_byteenable[0];
	assign wr_match_a = wr_take & (avs_address == tcc_pkg::OFF_MATCH_A);
	assign wr_match_b = wr_take & (avs_address == tcc_pkg::OFF_MATCH_B);
	assign wr_capture = wr_take & (avs_address == tcc_pkg::OFF_CAPTURE);
	// Strobe is a pulse from the write itself, nothing is stored
	assign force_a    = wr_force & avs_writedata[0] & ~pwm_mode;
	assign force_b    = wr_force & avs_writedata[1] & ~pwm_mode;

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wave_mode_sel_q    <= 4'h0;
			clk_sel_q          <= 3'h0;
			out_action_sel_a_q <= 2'h0;
			out_action_sel_b_q <= 2'h0;
		end else if (wr_ctrl) begin
			if (avs_byteenable[0]) begin
				wave_mode_sel_q <= avs_writedata[tcc_pkg::CTRL_MODE_LSB +: 4];
				clk_sel_q       <= avs_writedata[tcc_pkg::CTRL_CLK_LSB +: 3];
			end
			if (avs_byteenable[1]) begin
				out_action_sel_a_q <= avs_writedata[tcc_pkg::CTRL_ACT_A_LSB +: 2];
				out_action_sel_b_q <= avs_writedata[tcc_pkg::CTRL_ACT_B_LSB +: 2];
			end
		end
	end

	// Compare registers written directly, no double buffer
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			match_value_a_q <= 16'h0000;
			match_value_b_q <= 16'h0000;
		end else begin
			if (wr_match_a) begin
				match_value_a_q <= merge16(match_value_a_q, avs_writedata, avs_byteenable);
			end
			if (wr_match_b) begin
				match_value_b_q <= merge16(match_value_b_q, avs_writedata, avs_byteenable);
			end
		end
	end

	// Capture register: software sets top, events copy the count
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			capture_value_q <= 16'h0000;
		end else if (wr_capture) begin
			capture_value_q <= merge16(capture_value_q, avs_writedata, avs_byteenable);
		end else if (capture_event && !capture_sets_top(wave_mode_sel_q)) begin
			capture_value_q <= count_value_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			port_out_q     <= 2'h0;
			wave_pin_dir_q <= 2'h0;
		end else if (wr_port) begin
			port_out_q     <= avs_writedata[tcc_pkg::PORT_OUT_LSB +: 2];
			wave_pin_dir_q <= avs_writedata[tcc_pkg::PORT_DIR_LSB +: 2];
		end
	end

	// Prescaler: free-running divider, tick is the timer clock enable
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			div_q <= 10'h000;
		end else begin
			div_q <= div_q + 10'h001;
		end
	end

	always_comb begin
		unique case (clk_sel_q)
			tcc_pkg::CLK_DIV1:    tick = 1'b1;
			tcc_pkg::CLK_DIV8:    tick = div_done(div_q, tcc_pkg::DIV8_MASK);
			tcc_pkg::CLK_DIV64:   tick = div_done(div_q, tcc_pkg::DIV64_MASK);
			tcc_pkg::CLK_DIV256:  tick = div_done(div_q, tcc_pkg::DIV256_MASK);
			tcc_pkg::CLK_DIV1024: tick = div_done(div_q, tcc_pkg::DIV1024_MASK);
			default:              tick = 1'b0;
		endcase
	end

	// Mode decode: counting depends on the wave mode only
	assign ctc_mode = (wave_mode_sel_q == tcc_pkg::MODE_CTC_MATCH)
		| (wave_mode_sel_q == tcc_pkg::MODE_CTC_CAPT);
	assign pwm_mode = (wave_mode_sel_q != tcc_pkg::MODE_NORMAL) & ~ctc_mode;

	always_comb begin
		unique case (wave_mode_sel_q)
			tcc_pkg::MODE_CTC_MATCH, tcc_pkg::MODE_FAST_MTCH: top_value = match_value_a_q;
			tcc_pkg::MODE_CTC_CAPT, tcc_pkg::MODE_FAST_CAPT:  top_value = capture_value_q;
			tcc_pkg::MODE_FAST_8:  top_value = tcc_pkg::TOP_8;
			tcc_pkg::MODE_FAST_9:  top_value = tcc_pkg::TOP_9;
			tcc_pkg::MODE_FAST_10: top_value = tcc_pkg::TOP_10;
			default:               top_value = tcc_pkg::CNT_MAX;
		endcase
	end

	// Matches are suppressed for the tick after a counter write
	assign hit_a   = (count_value_q == match_value_a_q) & ~block_q;
	assign hit_b   = (count_value_q == match_value_b_q) & ~block_q;
	assign hit_top = (count_value_q == top_value) & ~block_q
		& (wave_mode_sel_q != tcc_pkg::MODE_NORMAL);
	assign at_max  = count_value_q == tcc_pkg::CNT_MAX;

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			block_q <= 1'b0;
		end else if (wr_count) begin
			block_q <= 1'b1;
		end else if (tick) begin
			block_q <= 1'b0;
		end
	end

	// Counter: software write wins over the tick
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			count_value_q <= tcc_pkg::CNT_FLOOR;
		end else if (wr_count) begin
			count_value_q <= merge16(count_value_q, avs_writedata, avs_byteenable);
		end else if (tick) begin
			if (hit_top) begin
				count_value_q <= tcc_pkg::CNT_FLOOR;
			end else begin
				count_value_q <= count_value_q + 16'h0001;
			end
		end
	end

	// Flags: hardware set wins over a write-one clear
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			overflow_flag_q <= 1'b0;
		end else if (tick && !wr_count && at_max) begin
			overflow_flag_q <= 1'b1;
		end else if (tick && !wr_count && hit_top && pwm_mode) begin
			overflow_flag_q <= 1'b1;
		end else if (wr_flags && avs_writedata[tcc_pkg::FLG_OVF]) begin
			overflow_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			match_flag_a_q <= 1'b0;
			match_flag_b_q <= 1'b0;
		end else begin
			if (tick && hit_a) begin
				match_flag_a_q <= 1'b1;
			end else if (wr_flags && avs_writedata[tcc_pkg::FLG_MA]) begin
				match_flag_a_q <= 1'b0;
			end
			if (tick && hit_b) begin
				match_flag_b_q <= 1'b1;
			end else if (wr_flags && avs_writedata[tcc_pkg::FLG_MB]) begin
				match_flag_b_q <= 1'b0;
			end
		end
	end

	// Capture flag: external event or top reached through capture register
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			capture_flag_q <= 1'b0;
		end else if (tick && hit_top && capture_sets_top(wave_mode_sel_q)) begin
			capture_flag_q <= 1'b1;
		end else if (capture_event && !capture_sets_top(wave_mode_sel_q)) begin
			capture_flag_q <= 1'b1;
		end else if (wr_flags && avs_writedata[tcc_pkg::FLG_CAP]) begin
			capture_flag_q <= 1'b0;
		end
	end

	// Output bits: real matches and forced strobes, non-PWM only.
	// Forcing touches neither flags nor counter; PWM waveforms not built here.
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wave_out_bit_a_q <= 1'b0;
			wave_out_bit_b_q <= 1'b0;
		end else begin
			if (force_a || (tick && hit_a && !pwm_mode)) begin
				wave_out_bit_a_q <= apply_action(wave_out_bit_a_q, out_action_sel_a_q);
			end
			if (force_b || (tick && hit_b && !pwm_mode)) begin
				wave_out_bit_b_q <= apply_action(wave_out_bit_b_q, out_action_sel_b_q);
			end
		end
	end
	// Mode changes do not touch the output bits

	// Pin override: action field selects source, direction stays with software
	always_ff @(posedge sys_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			wave_pin_q <= 2'h0;
		end else begin
			wave_pin_q[0] <= (out_action_sel_a_q != tcc_pkg::ACT_NONE)
				? wave_out_bit_a_q : port_out_q[0];
			wave_pin_q[1] <= (out_action_sel_b_q != tcc_pkg::ACT_NONE)
				? wave_out_bit_b_q : port_out_q[1];
		end
	end
	assign wave_pin_o  = wave_pin_q;
	assign wave_pin_oe = wave_pin_dir_q;

endmodule

`default_nettype wire

// >>> tcc_timer16_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tcc_timer16_checker (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        resetn,
	// Avalon-MM slave
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// Capture and pins
	input wire logic        capture_event,
	input wire logic [1:0]  wave_pin_o,
	input wire logic [1:0]  wave_pin_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic rd_done;
	logic wr_port;
	assign rd_done = avs_read && !avs_waitrequest;
	assign wr_port = avs_write && !avs_waitrequest && avs_address == tcc_pkg::OFF_PORT;
	property p_rst_pins;
		$rose(resetn) |-> wave_pin_o == 2'h0 && wave_pin_oe == 2'h0;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins not cleared by reset");
	property p_oe_src;
		$changed(wave_pin_oe) |-> $past(wr_port);
	endproperty
	a_oe_src: assert property (p_oe_src) else $error("pin direction changed without write");
	property p_oe_val;
		wr_port && avs_byteenable[0] |=> wave_pin_oe == $past(avs_writedata[3:2]);
	endproperty
	a_oe_val: assert property (p_oe_val) else $error("pin direction not taken from write");
	property p_wait_req;
		avs_waitrequest |-> avs_read || avs_write;
	endproperty
	a_wait_req: assert property (p_wait_req) else $error("wait without request");
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	property p_one_wait;
		$rose(avs_read || avs_write) |-> s_one_wait;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("answer not after one wait cycle");
	property p_rd_hi;
		rd_done |-> avs_readdata[31:16] == 16'h0000;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read half not zero");
	property p_force_rd;
		rd_done && avs_address == tcc_pkg::OFF_FORCE |-> avs_readdata == 32'h0;
	endproperty
	a_force_rd: assert property (p_force_rd) else $error("force strobe reads nonzero");
	property p_unmap;
		rd_done && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
	c_force: cover property (avs_write && !avs_waitrequest && avs_address == tcc_pkg::OFF_FORCE);
	c_oe: cover property ($changed(wave_pin_oe));
	c_pin: cover property ($changed(wave_pin_o));
endmodule
bind tcc_timer16 tcc_timer16_checker i_tcc_timer16_checker (.sys_clk(sys_clk), .resetn(resetn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.capture_event(capture_event), .wave_pin_o(wave_pin_o), .wave_pin_oe(wave_pin_oe));
`default_nettype wire

// >>> test_timer16_compare_output_ctc.sv
`timescale 1ns/1ns
`default_nettype none
module test_timer16_compare_output_ctc;
	localparam logic [4:0] R_CT = tcc_pkg::OFF_CTRL;
	localparam logic [4:0] R_CN = tcc_pkg::OFF_COUNT;
	localparam logic [4:0] R_MA = tcc_pkg::OFF_MATCH_A;
	localparam logic [4:0] R_MB = tcc_pkg::OFF_MATCH_B;
	localparam logic [4:0] R_CP = tcc_pkg::OFF_CAPTURE;
	localparam logic [4:0] R_FL = tcc_pkg::OFF_FLAGS;
	localparam logic [4:0] R_FO = tcc_pkg::OFF_FORCE;
	localparam logic [4:0] R_PT = tcc_pkg::OFF_PORT;
	localparam logic [31:0] F_OV = 32'h1 << tcc_pkg::FLG_OVF;
	localparam logic [31:0] F_MA = 32'h1 << tcc_pkg::FLG_MA;
	localparam logic [31:0] F_MB = 32'h1 << tcc_pkg::FLG_MB;
	localparam logic [31:0] F_CP = 32'h1 << tcc_pkg::FLG_CAP;
	localparam logic [1:0] AN = tcc_pkg::ACT_NONE;
	localparam logic [1:0] AT = tcc_pkg::ACT_TOGGLE;
	localparam logic [1:0] AC = tcc_pkg::ACT_CLEAR;
	localparam logic [1:0] AS = tcc_pkg::ACT_SET;
	localparam logic [3:0] M0 = tcc_pkg::MODE_NORMAL;
	localparam logic [2:0] C0 = tcc_pkg::CLK_STOP;
	localparam logic [2:0] C1 = tcc_pkg::CLK_DIV1;
	localparam logic [1:0] ACTS [5] = '{AS, AC, AT, AN, AT};
	localparam logic [1:0] EXPS [5] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h0};
	localparam logic [2:0] CS [5] = '{tcc_pkg::CLK_DIV1, tcc_pkg::CLK_DIV8,
		tcc_pkg::CLK_DIV64, tcc_pkg::CLK_DIV256, tcc_pkg::CLK_DIV1024};
	localparam int DV [5] = '{1, 8, 64, 256, 1024};
	localparam logic [3:0] MD [2] = '{tcc_pkg::MODE_CTC_MATCH, tcc_pkg::MODE_CTC_CAPT};
	localparam logic [4:0] TR [2] = '{R_MA, R_CP};
	localparam logic [31:0] FM [2] = '{F_MA, F_MA | F_CP};
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        capture_event = 1'b0;
	logic [1:0]  wave_pin_o;
	logic [1:0]  wave_pin_oe;
	logic [31:0] q;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;

	tcc_timer16 #(.CNT_W(16)) i_tcc_timer16 (.sys_clk(sys_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.capture_event(capture_event), .wave_pin_o(wave_pin_o), .wave_pin_oe(wave_pin_oe));

	always #20 sys_clk = ~sys_clk;

	task automatic end_sim();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic chk_rng(input string s, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] g);
		compares++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %s expected %h..%h seen %h", s, lo, hi, g);
		end
	endtask

	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic w;
		int   n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		w = 1'b1;
		n = 0;
		r = 32'h0;
		// Answer and read data are taken at the rising edge; a wait ends only when waitrequest is seen low
		while (w !== 1'b0) begin
			@(posedge sys_clk);
			w = avs_waitrequest;
			r = avs_readdata;
			n++;
		end
		chk("bus edges", 32'h2, 32'(n));
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0, q);
		chk(s, e, q);
	endtask

	function automatic logic [31:0] ctl(input logic [3:0] m, input logic [2:0] c,
		input logic [1:0] a);
		return {20'h00000, a, a, 1'b0, c, m};
	endfunction

	function automatic logic [31:0] pt(input logic [1:0] w);
		return {26'h0, w, 4'hC};
	endfunction

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 40000) begin
			miscompares++;
			end_sim();
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rdc(R_CT, 32'h0, "ctrl");
		rdc(R_PT, 32'h0, "port");
		rdc(5'h02, 32'h0, "unmapped");
		wr(R_PT, 32'h0000000C);
		chk("oe", 32'h3, {30'h0, wave_pin_oe});
		for (int i = 0; i < 5; i++) begin
			wr(R_CT, ctl(M0, C0, ACTS[i]));
			wr(R_FO, 32'h3);
			rdc(R_PT, pt(EXPS[i]), "wave");
			chk("pin", {30'h0, (ACTS[i] != AN) ? EXPS[i] : 2'h0}, {30'h0, wave_pin_o});
		end
		rdc(R_FL, 32'h0, "flags");
		rdc(R_CN, 32'h0, "count");
		wr(R_CT, ctl(M0, C0, AS));
		wr(R_FO, 32'h3);
		wr(R_CT, ctl(tcc_pkg::MODE_FAST_8, C0, AC));
		wr(R_FO, 32'h3);
		rdc(R_PT, pt(2'h3), "wave");
		rdc(R_FO, 32'h0, "force");
		wr(R_CT, ctl(M0, C0, AN));
		rdc(R_PT, pt(2'h3), "wave");
		wr(R_MA, 32'h5);
		wr(R_MB, 32'h5);
		wr(R_CN, 32'h5);
		wr(R_CT, ctl(M0, C1, AT));
		rdc(R_FL, 32'h0, "flags");
		wr(R_CT, ctl(M0, C0, AT));
		rdc(R_PT, pt(2'h3), "wave");
		wr(R_CN, 32'h3);
		wr(R_CT, ctl(M0, C1, AT));
		repeat (4) @(posedge sys_clk);
		rdc(R_FL, F_MA | F_MB, "flags");
		wr(R_CT, ctl(M0, C0, AT));
		rdc(R_PT, pt(2'h0), "wave");
		wr(R_MA, 32'h8000);
		wr(R_MB, 32'h8000);
		wr(R_CN, 32'hFFFE);
		wr(R_FL, 32'hF);
		wr(R_CT, ctl(M0, C1, AN));
		repeat (4) @(posedge sys_clk);
		rdc(R_FL, F_OV, "flags");
		wr(R_CN, 32'hFFF0);
		wr(R_CT, ctl(M0, C0, AN));
		bus(1'b0, R_CN, 32'h0, q);
		chk_rng("count", 32'hFFF0, 32'hFFFA, q);
		for (int k = 0; k < 2; k++) begin
			wr(R_CN, 32'h0);
			wr(TR[k], 32'h3);
			wr(R_FL, 32'hF);
			wr(R_CT, ctl(MD[k], C1, AT));
			repeat (40) @(posedge sys_clk);
			wr(R_CT, ctl(MD[k], C0, AT));
			bus(1'b0, R_CN, 32'h0, q);
			chk_rng("count", 32'h0, 32'h3, q);
			rdc(R_FL, FM[k], "flags");
		end
		for (int i = 0; i < 5; i++) begin
			wr(R_CN, 32'h0);
			wr(R_CT, ctl(M0, CS[i], AN));
			repeat (2048) @(posedge sys_clk);
			wr(R_CT, ctl(M0, C0, AN));
			bus(1'b0, R_CN, 32'h0, q);
			chk_rng("count", 2048 / DV[i] - 1, 2056 / DV[i] + 1, q);
		end
		wr(R_CN, 32'hAB);
		wr(R_FL, 32'hF);
		capture_event <= 1'b1;
		@(posedge sys_clk);
		capture_event <= 1'b0;
		rdc(R_CP, 32'hAB, "capture");
		rdc(R_FL, F_CP, "flags");
		end_sim();
	end
endmodule
`default_nettype wire
